/* File: inc/sdr_ctl_pkg.sv */
// Shared constants and types for the DRAM control-input front end.
package sdr_ctl_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 14;
    localparam int BANK_W  = 2;
    localparam int DATA_W  = 32;
    localparam int MASK_W  = 4;
    localparam int BURST_W = 4;

    // ------------------------------------------------------------------
    // Field positions and timing counts
    // ------------------------------------------------------------------
    localparam int AP_BIT       = 10;
    localparam int COL_MSB      = 9;
    localparam int MASK_LAT     = 2;
    localparam int BYTE_W       = 8;

    // Command code {cs_n, ras_n, cas_n, we_n}.
    typedef enum logic [3:0] {
        CMD_MRS  = 4'h0,
        CMD_REF  = 4'h1,
        CMD_PRE  = 4'h2,
        CMD_ACT  = 4'h3,
        CMD_WR   = 4'h4,
        CMD_BST  = 4'h6,
        CMD_RD   = 4'h5,
        CMD_NOP  = 4'h7,
        CMD_DESL = 4'h8
    } cmd_t;

    // Power state of the device.
    typedef enum logic [2:0] {
        PS_RUN   = 3'b000,
        PS_PPD   = 3'b001,
        PS_APD   = 3'b010,
        PS_SREF  = 3'b011,
        PS_DPD   = 3'b100,
        PS_SUSP  = 3'b101
    } pwr_t;

    localparam logic [BURST_W-1:0] BURST_RST = 4'h0;
    localparam logic [3:0]         BANKS_RST = 4'h0;

endpackage : sdr_ctl_pkg

/* File: inc/sdr_pins_if.sv */
// Pin bundle between the memory controller and the DRAM front end.
`timescale 1ns/10ps
interface sdr_pins_if;
    logic                             cke;
    logic                             cs_n;
    logic                             ras_n;
    logic                             cas_n;
    logic                             we_n;
    logic [sdr_ctl_pkg::BANK_W-1:0]   bank;
    logic [sdr_ctl_pkg::ADDR_W-1:0]   addr;
    logic [sdr_ctl_pkg::MASK_W-1:0]   dqm;
    logic [sdr_ctl_pkg::DATA_W-1:0]   dq_ctl_o;
    logic [sdr_ctl_pkg::DATA_W-1:0]   dq_ctl_oe;
    logic [sdr_ctl_pkg::DATA_W-1:0]   dq_mem_o;
    logic [sdr_ctl_pkg::DATA_W-1:0]   dq_mem_oe;
    logic [sdr_ctl_pkg::DATA_W-1:0]   dq;

    // Resolved bus level: whichever end enables a bit drives it.
    assign dq = (dq_ctl_o & dq_ctl_oe) | (dq_mem_o & dq_mem_oe);

    modport ctl (
        output cke, cs_n, ras_n, cas_n, we_n, bank, addr, dqm,
        output dq_ctl_o, dq_ctl_oe,
        input  dq
    );
    modport mem (
        input  cke, cs_n, ras_n, cas_n, we_n, bank, addr, dqm,
        output dq_mem_o, dq_mem_oe,
        input  dq
    );
endinterface : sdr_pins_if

/* File: design/lane_mask.sv */
// Byte-lane mask mapping with a programmable read latency.
`timescale 1ns/10ps
module lane_mask #(
    parameter int LANES = 4,
    parameter int LAT   = 2
) (
    // Clock and control
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 ce,
    // Mask in, per-bit enables out
    input  wire logic [LANES-1:0]     mask,
    output logic      [LANES*8-1:0]   bit_keep,
    output logic      [LANES*8-1:0]   bit_keep_dly
);
    logic [LANES-1:0] pipe_q [LAT];

    // Each mask bit owns one byte lane.
    function automatic logic [LANES*8-1:0] spread(input logic [LANES-1:0] m);
        logic [LANES*8-1:0] r;
        r = '0;
        for (int i = 0; i < LANES; i++) begin
            r[i*8 +: 8] = {8{~m[i]}};
        end
        return r;
    endfunction : spread

    assign bit_keep     = spread(mask);
    assign bit_keep_dly = spread(pipe_q[LAT-1]);

    // Read mask delayed by LAT edges.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < LAT; i++) pipe_q[i] <= '1;
        end else if (ce) begin
            pipe_q[0] <= mask;
            for (int i = 1; i < LAT; i++) pipe_q[i] <= pipe_q[i-1];
        end
    end
endmodule : lane_mask

/* File: design/sdr_mem_end.sv */
// Device end: samples command, clock-enable, mask and bank inputs.
//
// Function
// - All inputs sampled on rising clock only.
// - Burst counter and output data clocked.
// - Registered CKE high runs, low stops.
// - All idle: power-down, self refresh, deep.
// - Open row, no burst: active power-down.
// - Burst running: clock suspend freezes burst.
// - CKE pin sampled on the rising clock while powered down.
// - Receivers off during power-down or refresh.
// - Commands ignored while chip select high.
// - Command decoded from all four strobes.
// - Masked write lanes are discarded.
// - Masked read lanes float two cycles later.
// - Sixteen-bit lanes: low and high mask.
// - Thirty-two-bit: mask n owns lane n.
// - Bank inputs pick target bank.
// - All-bank precharge ignores bank inputs.
// - Address bit ten selects all-bank precharge.
// - Low bits column, bit ten auto precharge.
// - Mode op-code captured from address.
`timescale 1ns/10ps
module sdr_mem_end #(
    parameter int BURST_LEN = 4
) (
    // Clock and control
    input  wire logic                               sys_clk,
    input  wire logic                               reset,
    input  wire logic                               ce,
    // Pins
    sdr_pins_if.mem                                 pins,
    // Array side
    output logic                                    wr_stb,
    output logic      [sdr_ctl_pkg::BANK_W-1:0]     wr_bank,
    output logic      [sdr_ctl_pkg::COL_MSB:0]      wr_col,
    output logic      [sdr_ctl_pkg::DATA_W-1:0]     wr_data,
    output logic      [sdr_ctl_pkg::DATA_W-1:0]     wr_keep,
    input  wire logic [sdr_ctl_pkg::DATA_W-1:0]     rd_data,
    output logic      [sdr_ctl_pkg::ADDR_W-1:0]     mode_q,
    output logic      [3:0]                         open_q,
    output logic                                    auto_pre_q,
    output sdr_ctl_pkg::pwr_t                       pwr_q,
    output logic                                    rx_on_q
);
    // ------------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------------
    logic                             cke_q;
    logic [3:0]                       cmd_raw;
    logic [sdr_ctl_pkg::BURST_W-1:0]  burst_q;
    logic [sdr_ctl_pkg::DATA_W-1:0]   keep_now;
    logic [sdr_ctl_pkg::DATA_W-1:0]   keep_late;
    logic [sdr_ctl_pkg::DATA_W-1:0]   dq_o_q;
    logic [sdr_ctl_pkg::DATA_W-1:0]   dq_oe_q;
    logic                             rd_act_q;
    logic [sdr_ctl_pkg::BANK_W-1:0]   bank_q;
    logic [sdr_ctl_pkg::COL_MSB:0]    col_q;

    typedef logic [sdr_ctl_pkg::BURST_W-1:0] burst_t;

    // Command formed from all four strobes.
    assign cmd_raw = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};

    // Chip select high masks every command.
    wire        sel     = ~pins.cs_n;
    wire        awake   = (pwr_q == sdr_ctl_pkg::PS_RUN) && cke_q;
    wire        live    = ce && awake && sel;
    wire        is_pre  = live && cmd_raw == sdr_ctl_pkg::CMD_PRE;
    wire        is_act  = live && cmd_raw == sdr_ctl_pkg::CMD_ACT;
    wire        is_rd   = live && cmd_raw == sdr_ctl_pkg::CMD_RD;
    wire        is_wr   = live && cmd_raw == sdr_ctl_pkg::CMD_WR;
    wire        is_mrs  = live && cmd_raw == sdr_ctl_pkg::CMD_MRS;
    wire        is_ref  = ce && sel && cmd_raw == sdr_ctl_pkg::CMD_REF;
    wire        is_bst  = ce && sel && cmd_raw == sdr_ctl_pkg::CMD_BST;
    wire        all_pre = pins.addr[sdr_ctl_pkg::AP_BIT];
    wire        bursting = burst_q != sdr_ctl_pkg::BURST_RST;
    wire [3:0]  bank_hot = 4'h1 << pins.bank;

    // Bank inputs ignored for all-bank precharge.
    wire [3:0]  pre_clr = all_pre ? 4'hf : bank_hot;

    lane_mask #(
        .LANES (sdr_ctl_pkg::MASK_W),
        .LAT   (sdr_ctl_pkg::MASK_LAT)
    ) u_mask (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .ce           (ce && rx_on_q),
        .mask         (pins.dqm),
        .bit_keep     (keep_now),
        .bit_keep_dly (keep_late)
    );

    // ------------------------------------------------------------------
    // Clock enable and power state
    // ------------------------------------------------------------------
    sdr_ctl_pkg::pwr_t pwr_d;

    // Entry chosen by bank state and command.
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            sdr_ctl_pkg::PS_RUN: begin
                if (!pins.cke && cke_q) begin
                    if (bursting)
                        pwr_d = sdr_ctl_pkg::PS_SUSP;
                    else if (open_q != 4'h0)
                        pwr_d = sdr_ctl_pkg::PS_APD;
                    else if (is_ref)
                        pwr_d = sdr_ctl_pkg::PS_SREF;
                    else if (is_bst)
                        pwr_d = sdr_ctl_pkg::PS_DPD;
                    else
                        pwr_d = sdr_ctl_pkg::PS_PPD;
                end
            end
            // Exit sensed directly from the pin.
            sdr_ctl_pkg::PS_PPD, sdr_ctl_pkg::PS_APD,
            sdr_ctl_pkg::PS_SREF, sdr_ctl_pkg::PS_DPD,
            sdr_ctl_pkg::PS_SUSP: begin
                if (pins.cke)
                    pwr_d = sdr_ctl_pkg::PS_RUN;
            end
            default: pwr_d = sdr_ctl_pkg::PS_RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pwr_q   <= sdr_ctl_pkg::PS_RUN;
            cke_q   <= 1'b1;
            rx_on_q <= 1'b1;
        end else if (ce) begin
            pwr_q   <= pwr_d;
            cke_q   <= pins.cke;
            // Receivers idle in power-down or refresh.
            rx_on_q <= pwr_d == sdr_ctl_pkg::PS_RUN ||
                       pwr_d == sdr_ctl_pkg::PS_SUSP;
        end
    end

    // ------------------------------------------------------------------
    // Bank, address and burst tracking
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            open_q     <= sdr_ctl_pkg::BANKS_RST;
            mode_q     <= '0;
            auto_pre_q <= 1'b0;
            bank_q     <= '0;
            col_q      <= '0;
        end else begin
            // Bank inputs address the row command.
            if (is_act)
                open_q <= open_q | bank_hot;
            // Bit ten picks all or one bank.
            else if (is_pre)
                open_q <= open_q & ~pre_clr;
            // Op-code taken from the address pins.
            if (is_mrs)
                mode_q <= pins.addr;
            // Column from low bits, bit ten auto precharge.
            if (is_rd || is_wr) begin
                bank_q     <= pins.bank;
                col_q      <= pins.addr[sdr_ctl_pkg::COL_MSB:0];
                auto_pre_q <= all_pre;
            end else if (awake && ce && bursting) begin
                col_q <= col_q + 1'b1;
            end
        end
    end

    // Burst counter counts down on each enabled clock while awake and holds at zero.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            burst_q  <= sdr_ctl_pkg::BURST_RST;
            rd_act_q <= 1'b0;
        end else if (is_rd || is_wr) begin
            burst_q  <= burst_t'(BURST_LEN);
            rd_act_q <= is_rd;
        end else if (ce && awake && bursting) begin
            burst_q  <= burst_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    wire wr_beat = ce && awake && !rd_act_q && bursting;

    assign wr_keep = keep_now;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_stb  <= 1'b0;
            wr_bank <= '0;
            wr_col  <= '0;
            wr_data <= '0;
        end else if (ce) begin
            wr_stb  <= wr_beat;
            wr_bank <= bank_q;
            wr_col  <= col_q;
            wr_data <= pins.dq & keep_now;
        end
    end

    // Output register clocked; late mask floats lane.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dq_o_q  <= '0;
            dq_oe_q <= '0;
        end else if (ce && awake) begin
            dq_o_q  <= rd_data;
            dq_oe_q <= (rd_act_q && bursting) ? keep_late : '0;
        end
    end

    assign pins.dq_mem_o  = dq_o_q;
    assign pins.dq_mem_oe = dq_oe_q;
endmodule : sdr_mem_end

/* File: design/sdr_ctl_end.sv */
// Controller end: drives command, clock-enable, mask and bank pins.
`timescale 1ns/10ps
module sdr_ctl_end (
    // Clock and control
    input  wire logic                               sys_clk,
    input  wire logic                               reset,
    input  wire logic                               ce,
    // User request
    input  wire logic                               req_valid,
    input  wire sdr_ctl_pkg::cmd_t                  req_cmd,
    input  wire logic [sdr_ctl_pkg::BANK_W-1:0]     req_bank,
    input  wire logic [sdr_ctl_pkg::ADDR_W-1:0]     req_addr,
    input  wire logic [sdr_ctl_pkg::MASK_W-1:0]     req_mask,
    input  wire logic [sdr_ctl_pkg::DATA_W-1:0]     req_wdata,
    input  wire logic                               req_wdrive,
    input  wire logic                               req_cke,
    output logic      [sdr_ctl_pkg::DATA_W-1:0]     rd_data_q,
    // Pins
    sdr_pins_if.ctl                                 pins
);
    // ------------------------------------------------------------------
    // Pin registers
    // ------------------------------------------------------------------
    logic [3:0] cmd_q;
    logic       cke_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cke_q          <= 1'b1;
            cmd_q          <= sdr_ctl_pkg::CMD_DESL;
            pins.bank      <= '0;
            pins.addr      <= '0;
            pins.dqm       <= '1;
            pins.dq_ctl_o  <= '0;
            pins.dq_ctl_oe <= '0;
            rd_data_q      <= '0;
        end else if (ce) begin
            cke_q          <= req_cke;
            // One command per edge on four strobes.
            cmd_q          <= req_valid ? req_cmd : sdr_ctl_pkg::CMD_NOP;
            // Bank valid with the command; op-code on address.
            pins.bank      <= req_bank;
            pins.addr      <= req_addr;
            // Lanes to preserve carry a high mask.
            pins.dqm       <= req_mask;
            pins.dq_ctl_o  <= req_wdata;
            pins.dq_ctl_oe <= {sdr_ctl_pkg::DATA_W{req_wdrive}};
            rd_data_q      <= pins.dq;
        end
    end

    assign pins.cke   = cke_q;
    assign pins.cs_n  = cmd_q[3];
    assign pins.ras_n = cmd_q[2];
    assign pins.cas_n = cmd_q[1];
    assign pins.we_n  = cmd_q[0];
endmodule : sdr_ctl_end

/* File: test/sdr_ctl_props.sv */
// Concurrent checks on the pins between controller and device ends.
`timescale 1ns/10ps
module sdr_ctl_props (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               reset,
    input wire logic               ce,
    // Pins
    input wire logic               cke,
    input wire logic               cs_n,
    input wire logic               ras_n,
    input wire logic               cas_n,
    input wire logic               we_n,
    input wire logic [1:0]         bank,
    input wire logic [13:0]        addr,
    input wire logic [3:0]         dqm,
    input wire logic [31:0]        dq_mem_oe,
    // Device state
    input wire logic [3:0]         open_q,
    input wire logic [13:0]        mode_q,
    input wire logic [31:0]        wr_keep,
    input wire sdr_ctl_pkg::pwr_t  pwr_q,
    input wire logic               rx_on_q
);
    wire [3:0] cmd_w = {cs_n, ras_n, cas_n, we_n};
    wire       idle_w = ce && pwr_q == sdr_ctl_pkg::PS_RUN;
    wire       run_w  = idle_w && cke;
    wire       all_w  = addr[sdr_ctl_pkg::AP_BIT];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    AST_CS_IGNORE: assert property (cs_n |=> $stable(mode_q))
        else $error("mode changed while chip select high");
    AST_MRS_CAPTURE: assert property (run_w && cmd_w == 4'h0 |=>
        mode_q == $past(addr)) else $error("mode not captured");
    AST_ACT_OPEN: assert property (run_w && cmd_w == 4'h3 |=>
        open_q[$past(bank)]) else $error("bank not opened");
    AST_PRE_ALL: assert property (run_w && cmd_w == 4'h2 && all_w |=>
        open_q == 4'h0) else $error("all-bank precharge left a bank open");
    AST_HALT_IGNORE: assert property (pwr_q != sdr_ctl_pkg::PS_RUN |=>
        $stable(open_q)) else $error("bank state moved while halted");

    // ------------------------------------------------------------------
    // Byte masks
    // ------------------------------------------------------------------
    AST_KEEP_MAP: assert property (wr_keep == {{8{~dqm[3]}},
        {8{~dqm[2]}}, {8{~dqm[1]}}, {8{~dqm[0]}}})
        else $error("write keep does not follow byte mask");
    AST_FLOAT_LO: assert property (dqm[0] [*5] |->
        dq_mem_oe[7:0] == 8'h00) else $error("lane 0 still driven");
    AST_FLOAT_HI: assert property (dqm[3] [*5] |->
        dq_mem_oe[31:24] == 8'h00) else $error("lane 3 still driven");

    // ------------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------------
    AST_SREF_ENTRY: assert property (idle_w && !cke && cmd_w == 4'h1
        && open_q == 4'h0 |-> ##[1:2] pwr_q == sdr_ctl_pkg::PS_SREF)
        else $error("self refresh not entered");
    AST_RX_OFF: assert property (
        pwr_q == sdr_ctl_pkg::PS_SREF [*2] |-> !rx_on_q)
        else $error("receivers on in self refresh");

    COV_ACT: cover property (run_w && cmd_w == 4'h3);
    COV_SREF: cover property (pwr_q == sdr_ctl_pkg::PS_SREF);
    COV_SUSP: cover property (pwr_q == sdr_ctl_pkg::PS_SUSP);
endmodule : sdr_ctl_props

/* File: test/sdr_control_input_decode_bench.sv */
// Bench joining both ends with a behavioural model and a checker.
`timescale 1ns/10ps
module sdr_control_input_decode_bench;
    localparam int BL = 4;
    logic               sys_clk    = 1'b0;
    logic               reset      = 1'b1;
    logic               ce         = 1'b1;
    logic               req_valid  = 1'b0;
    sdr_ctl_pkg::cmd_t  req_cmd    = sdr_ctl_pkg::CMD_NOP;
    logic [1:0]         req_bank   = 2'h0;
    logic [13:0]        req_addr   = 14'h0000;
    logic [3:0]         req_mask   = 4'hf;
    logic [31:0]        req_wdata  = 32'h00000000;
    logic               req_wdrive = 1'b0;
    logic               req_cke    = 1'b1;
    logic [31:0]        rd_data    = 32'h00000000;
    logic [31:0]        rd_data_q, wr_data, wr_keep, seed = 32'h00000016;
    logic               wr_stb, rx_on_q;
    logic [1:0]         wr_bank;
    logic [9:0]         wr_col;
    logic               auto_pre_q, m_ap = 1'b0;
    logic [3:0]         dqm_h1, dqm_h2;
    logic [31:0]        rd_exp1, rd_exp2;
    logic [13:0]        mode_q, m_mode;
    logic [3:0]         open_q, m_open = 4'h0;
    sdr_ctl_pkg::pwr_t  pwr_q;
    logic [31:0]        exp_wd[$];
    logic [31:0]        exp_wb[$], exp_wc[$];
    int                 error_cnt = 0, total_checks = 0, cyc = 0;

    always #4 sys_clk = ~sys_clk;
    sdr_pins_if pins ();
    sdr_ctl_end sdr_ctl_end_inst (.sys_clk(sys_clk), .reset(reset),
        .ce(ce), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_bank(req_bank), .req_addr(req_addr), .req_mask(req_mask),
        .req_wdata(req_wdata), .req_wdrive(req_wdrive),
        .req_cke(req_cke), .rd_data_q(rd_data_q), .pins(pins));
    sdr_mem_end #(.BURST_LEN(BL)) sdr_mem_end_inst (.sys_clk(sys_clk),
        .reset(reset), .ce(ce), .pins(pins), .wr_stb(wr_stb),
        .wr_bank(wr_bank), .wr_col(wr_col), .wr_data(wr_data),
        .wr_keep(wr_keep), .rd_data(rd_data), .mode_q(mode_q),
        .open_q(open_q), .auto_pre_q(auto_pre_q), .pwr_q(pwr_q),
        .rx_on_q(rx_on_q));
    sdr_ctl_props sdr_ctl_props_inst (.sys_clk(sys_clk), .reset(reset),
        .ce(ce), .cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
        .cas_n(pins.cas_n), .we_n(pins.we_n), .bank(pins.bank),
        .addr(pins.addr), .dqm(pins.dqm), .dq_mem_oe(pins.dq_mem_oe),
        .open_q(open_q), .mode_q(mode_q), .wr_keep(wr_keep),
        .pwr_q(pwr_q), .rx_on_q(rx_on_q));

    function automatic logic [31:0] lfsr_f(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_f

    function automatic logic [31:0] keep_f(input logic [3:0] m);
        return {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
    endfunction : keep_f

    task automatic check_val(input string nm, input logic [31:0] seen,
                             input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check_val

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    // Model update happens as the request is handed over.
    task automatic issue(input sdr_ctl_pkg::cmd_t c, input logic [1:0] b,
                         input logic [13:0] a, input logic k);
        @(negedge sys_clk);
        req_valid  = 1'b1;
        req_cmd    = c;
        req_bank   = b;
        req_addr   = a;
        req_cke    = k;
        // Write data must stay driven through the whole burst.
        if (c == sdr_ctl_pkg::CMD_WR) req_wdrive = 1'b1;
        if (c == sdr_ctl_pkg::CMD_RD) req_wdrive = 1'b0;
        if (c == sdr_ctl_pkg::CMD_WR || c == sdr_ctl_pkg::CMD_RD) m_ap = a[10];
        if (k && c == sdr_ctl_pkg::CMD_ACT) m_open[b] = 1'b1;
        if (k && c == sdr_ctl_pkg::CMD_PRE) begin
            if (a[10]) m_open = 4'h0;
            else m_open[b] = 1'b0;
        end
        if (k && c == sdr_ctl_pkg::CMD_MRS) m_mode = a;
        for (int i = 0; i < BL && c == sdr_ctl_pkg::CMD_WR; i++) begin
            exp_wd.push_back(req_wdata & keep_f(req_mask));
            exp_wb.push_back(32'(b));
            exp_wc.push_back(32'(10'(a[9:0] + i)));
        end
    endtask : issue

    task automatic idle(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            req_valid = 1'b0;
            req_cmd   = sdr_ctl_pkg::CMD_NOP;
        end
    endtask : idle

    // A lingering state change is given eight cycles to appear.
    task automatic wait_pwr(input logic in_run);
        for (int n = 0; n < 8 && ((pwr_q === sdr_ctl_pkg::PS_RUN) == in_run);
             n++) @(negedge sys_clk);
    endtask : wait_pwr

    // Read model: a lane mask floats the data two edges after sampling.
    always @(posedge sys_clk) begin
        dqm_h1  <= pins.dqm;
        dqm_h2  <= dqm_h1;
        rd_exp1 <= rd_data & keep_f(dqm_h2);
        rd_exp2 <= rd_exp1;
    end

    always @(negedge sys_clk) begin
        seed = lfsr_f(seed);
        rd_data <= seed;
        if (!reset && wr_stb === 1'b1) begin
            if (exp_wd.size() == 0) check_val("wr_extra", 1, 0);
            else begin
                check_val("wr_data", wr_data, exp_wd.pop_front());
                check_val("wr_bank", 32'(wr_bank), exp_wb.pop_front());
                check_val("wr_col", 32'(wr_col), exp_wc.pop_front());
            end
        end
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    sdr_ctl_pkg::cmd_t pc[4] = '{sdr_ctl_pkg::CMD_REF, sdr_ctl_pkg::CMD_BST,
                                 sdr_ctl_pkg::CMD_NOP, sdr_ctl_pkg::CMD_NOP};
    sdr_ctl_pkg::pwr_t pe[4] = '{sdr_ctl_pkg::PS_SREF, sdr_ctl_pkg::PS_DPD,
                                 sdr_ctl_pkg::PS_PPD, sdr_ctl_pkg::PS_APD};

    initial begin
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        check_val("open_rst", 32'(open_q), 0);
        check_val("pwr_rst", 32'(pwr_q), 32'(sdr_ctl_pkg::PS_RUN));
        // Back-to-back mode loads, then a deselected load.
        issue(sdr_ctl_pkg::CMD_MRS, 2'h0, seed[13:0], 1'b1);
        issue(sdr_ctl_pkg::CMD_MRS, 2'h1, seed[17:4], 1'b1);
        idle(2);
        check_val("mode", 32'(mode_q), 32'(m_mode));
        issue(sdr_ctl_pkg::CMD_DESL, 2'h0, ~m_mode, 1'b1);
        idle(2);
        check_val("mode_desl", 32'(mode_q), 32'(m_mode));
        $display("test mode done");
        for (int i = 0; i < 4; i++)
            issue(sdr_ctl_pkg::CMD_ACT, 2'(3 - i), seed[13:0], 1'b1);
        issue(sdr_ctl_pkg::CMD_PRE, 2'h2, 14'h0000, 1'b1);
        idle(2);
        check_val("open_one", 32'(open_q), 32'(m_open));
        issue(sdr_ctl_pkg::CMD_PRE, seed[1:0], 14'h0400, 1'b1);
        idle(2);
        check_val("open_all", 32'(open_q), 32'(m_open));
        $display("test banks done");
        for (int i = 0; i < 4; i++)
            issue(sdr_ctl_pkg::CMD_ACT, 2'(i), 14'h0000, 1'b1);
        for (int i = 0; i < 6; i++) begin
            req_mask  = seed[3:0];
            req_wdata = seed;
            issue(sdr_ctl_pkg::CMD_WR, 2'(i), {3'h0, seed[10:0]}, 1'b1);
            idle(BL + 3);
            check_val("auto_pre", 32'(auto_pre_q), 32'(m_ap));
        end
        check_val("wr_left", exp_wd.size(), 0);
        // Mask changes during the read exercise the two-edge float delay.
        req_mask = 4'h9;
        issue(sdr_ctl_pkg::CMD_RD, 2'h1, 14'h0400, 1'b1);
        for (int i = 1; i < 8; i++) begin
            idle(1);
            req_mask = seed[3:0];
            if (i >= 4) check_val("rd_data", rd_data_q, rd_exp2);
        end
        check_val("auto_pre_rd", 32'(auto_pre_q), 32'(m_ap));
        idle(1);
        issue(sdr_ctl_pkg::CMD_PRE, 2'h0, 14'h0400, 1'b1);
        idle(2);
        $display("test data done");
        for (int i = 0; i < 4; i++) begin
            if (i == 3) issue(sdr_ctl_pkg::CMD_ACT, 2'h1, 14'h0000, 1'b1);
            issue(pc[i], 2'h0, 14'h0000, 1'b0);
            wait_pwr(1'b1);
            check_val("pwr_in", 32'(pwr_q), 32'(pe[i]));
            if (i == 0) check_val("rx_on", 32'(rx_on_q), 0);
            issue(sdr_ctl_pkg::CMD_NOP, 2'h0, 14'h0000, 1'b1);
            wait_pwr(1'b0);
            check_val("pwr_out", 32'(pwr_q), 32'(sdr_ctl_pkg::PS_RUN));
        end
        req_wdata = seed;
        issue(sdr_ctl_pkg::CMD_WR, 2'h1, 14'h0000, 1'b1);
        issue(sdr_ctl_pkg::CMD_NOP, 2'h0, 14'h0000, 1'b0);
        wait_pwr(1'b1);
        check_val("pwr_susp", 32'(pwr_q), 32'(sdr_ctl_pkg::PS_SUSP));
        idle(4);
        issue(sdr_ctl_pkg::CMD_NOP, 2'h0, 14'h0000, 1'b1);
        idle(BL + 6);
        check_val("susp_left", exp_wd.size(), 0);
        check_val("open_end", 32'(open_q), 32'(m_open));
        $display("test power done");
        give_verdict();
    end
endmodule : sdr_control_input_decode_bench
